/* verilog/swr_supervisor.sv */
// Supervisor top: kick watchdog, reset generator, enable switchover
`timescale 1ns/10ps

module swr_supervisor #(
   parameter bit GATED        = 1'b0,
   parameter int TICK_CYCLES  = swr_pkg::TICK_CYC,
   parameter int SWITCH_DELAY = swr_pkg::SWITCH_CYC
) (
   input  wire logic             clk_in,
   input  wire logic             arst_n_in,
   input  wire swr_pkg::swr_cfg_t cfg_in,
   input  wire logic             supply_monitor_in,
   input  wire logic             gate_in,
   input  wire logic             watchdog_kick_in,
   output logic                  reset_n_out,
   output logic                  reset_oe_n_out,
   output logic                  enable_n_out,
   output logic                  enable_oe_n_out
);

   localparam int CW = swr_pkg::CNT_W;
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int KW = $clog2(swr_pkg::KICK_MIN_CYC + 1);
   localparam int DW = $clog2(swr_pkg::REDL_CYC + 1);
   localparam int SW = $clog2(SWITCH_DELAY + 1);
   if (SWITCH_DELAY < 1 || TICK_CYCLES < 1 ||
       swr_pkg::KICK_MIN_CYC <= swr_pkg::KICK_IGN_CYC) begin : g_chk
      $error("swr_supervisor: unusable timing parameters");
   end

   function automatic logic [CW-1:0] clampv(input logic [CW-1:0] v,
                                             input logic [CW-1:0] lo,
                                             input logic [CW-1:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   typedef enum logic {WD_OFF, WD_RUN} swr_wd_t;
   typedef enum logic [1:0] {RST_HOLD, RST_TIME, RST_IDLE} swr_rst_t;

   // ----------------------------------------------------------------
   // Microsecond timebase
   // ----------------------------------------------------------------
   logic [TW-1:0] tick_cnt_q;
   logic          tick_q;
   wire           tick_wrap = tick_cnt_q == TW'(TICK_CYCLES - 1);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else begin
         tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + TW'(1);
         tick_q     <= tick_wrap;
      end
   end

   // ----------------------------------------------------------------
   // Kick pulse filter
   // ----------------------------------------------------------------
   // Narrow glitches clear the count when they fall, so they cannot kick
   logic [KW-1:0] kick_cnt_q;
   wire kick_full  = kick_cnt_q == KW'(swr_pkg::KICK_MIN_CYC);
   wire kick_pulse = watchdog_kick_in &&
                     kick_cnt_q == KW'(swr_pkg::KICK_MIN_CYC - 1);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         kick_cnt_q <= '0;
      end else if (!watchdog_kick_in) begin
         kick_cnt_q <= '0;
      end else if (!kick_full) begin
         kick_cnt_q <= kick_cnt_q + KW'(1);
      end
   end

   // ----------------------------------------------------------------
   // Period selection
   // ----------------------------------------------------------------
   swr_wd_t       wd_state_q;
   logic [CW-1:0] wd_cnt_q;
   logic          first_q;
   wire [CW-1:0]  wd_period = clampv(CW'(cfg_in.kick_period),
                                     swr_pkg::WP_MIN, swr_pkg::WP_MAX);
   wire [CW-1:0]  rst_lim   = clampv(CW'(cfg_in.reset_period),
                                     swr_pkg::RST_MIN, swr_pkg::RST_MAX);
   wire [CW-1:0]  wd_long   = {wd_period[swr_pkg::WP_W-1:0], 3'h0};
   wire [CW-1:0]  wd_limit  = first_q ? wd_long : wd_period;
   wire [CW-1:0]  early     =
      (cfg_in.window == swr_pkg::WIN_50) ? (wd_limit >> 1) :
      (cfg_in.window == swr_pkg::WIN_75) ? (wd_limit >> 2) : '0;

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   swr_rst_t rst_state_q;
   swr_rst_t rst_state_d;
   logic [CW-1:0] rst_cnt_q;
   logic [CW-1:0] rst_cnt_d;
   wire rst_idle   = rst_state_q == RST_IDLE;
   wire wd_run     = GATED ? gate_in : rst_idle;
   wire wd_on      = wd_state_q == WD_RUN;
   wire wd_expire  = wd_on && tick_q && wd_cnt_q >= wd_limit - CW'(1);
   wire kick_early = wd_on && kick_pulse && wd_cnt_q < early;
   wire kick_ok    = wd_on && kick_pulse && !kick_early;
   wire wd_fault   = kick_early || wd_expire;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wd_state_q <= WD_OFF;
         wd_cnt_q   <= '0;
         first_q    <= 1'b0;
      end else if (!wd_run) begin
         wd_state_q <= WD_OFF;
         wd_cnt_q   <= '0;
         first_q    <= GATED;
      end else begin
         wd_state_q <= WD_RUN;
         if (wd_fault || kick_ok) begin
            wd_cnt_q <= '0;
            first_q  <= 1'b0;
         end else if (tick_q) begin
            wd_cnt_q <= wd_cnt_q + CW'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // Reset generator
   // ----------------------------------------------------------------
   // Gated variant reuses the generator as the enable source
   wire rst_cond = (GATED ? !gate_in : !supply_monitor_in) ||
                   wd_fault;
   always_comb begin
      rst_state_d = rst_state_q;
      rst_cnt_d   = rst_cnt_q;
      if (rst_cond) begin
         rst_state_d = RST_HOLD;
         rst_cnt_d   = '0;
      end else begin
         unique case (rst_state_q)
            RST_HOLD: begin
               rst_state_d = RST_TIME;
               rst_cnt_d   = '0;
            end
            RST_TIME: begin
               if (tick_q && rst_cnt_q == rst_lim - CW'(1)) begin
                  rst_state_d = RST_IDLE;
               end else if (tick_q) begin
                  rst_cnt_d = rst_cnt_q + CW'(1);
               end
            end
            RST_IDLE: rst_state_d = RST_IDLE;
            default:  rst_state_d = RST_HOLD;
         endcase
      end
   end

   logic reset_n_q;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_state_q <= RST_HOLD;
         rst_cnt_q   <= '0;
         reset_n_q   <= GATED;
      end else begin
         rst_state_q <= rst_state_d;
         rst_cnt_q   <= rst_cnt_d;
         reset_n_q   <= GATED || rst_state_d == RST_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // Enable follower and switchover
   // ----------------------------------------------------------------
   logic          en_follow_q;
   logic [DW-1:0] en_cnt_q;
   logic [1:0]    fault_cnt_q;
   logic          ovr_run_q;
   logic [SW-1:0] ovr_cnt_q;
   logic          sw_over_q;
   logic          enable_n_q;
   wire rst_act  = !rst_idle;
   wire en_wrap  = en_cnt_q == DW'(swr_pkg::REDL_CYC - 1);
   wire third    = wd_fault && fault_cnt_q == 2'h2;
   wire ovr_wrap = ovr_cnt_q == SW'(SWITCH_DELAY - 1);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         en_follow_q <= 1'b1;
         en_cnt_q    <= '0;
      end else if (rst_act == en_follow_q) begin
         en_cnt_q    <= '0;
      end else if (en_wrap) begin
         en_follow_q <= rst_act;
         en_cnt_q    <= '0;
      end else begin
         en_cnt_q    <= en_cnt_q + DW'(1);
      end
   end

   // Fault tally is sticky until power-on reset: switchover is final
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fault_cnt_q <= 2'h0;
         ovr_run_q   <= 1'b0;
         ovr_cnt_q   <= '0;
         sw_over_q   <= 1'b0;
      end else begin
         if (wd_fault && fault_cnt_q != 2'h3) begin
            fault_cnt_q <= fault_cnt_q + 2'h1;
         end
         if (third) begin
            ovr_run_q <= 1'b1;
         end else if (ovr_run_q && ovr_wrap) begin
            ovr_run_q <= 1'b0;
            sw_over_q <= 1'b1;
         end
         if (ovr_run_q && !ovr_wrap) begin
            ovr_cnt_q <= ovr_cnt_q + SW'(1);
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enable_n_q <= 1'b0;
      end else begin
         enable_n_q <= !(en_follow_q || sw_over_q);
      end
   end

   assign reset_n_out     = reset_n_q;
   assign reset_oe_n_out  = reset_n_q;
   assign enable_n_out    = enable_n_q;
   assign enable_oe_n_out = enable_n_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   localparam int ST_LAT = 1;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   AST_SUPPLY_RESET: assert property (
      !GATED && !supply_monitor_in |-> ##[1:ST_LAT] !reset_n_out)
      else $error("reset not asserted after supply fall");
   AST_FAULT_RESET: assert property (
      !GATED && wd_fault |=> !reset_n_out && rst_state_q == RST_HOLD)
      else $error("watchdog fault did not assert reset");
   AST_RELEASE_TIME: assert property (
      !GATED && $rose(reset_n_out) |->
      $past(rst_cnt_q) == $past(rst_lim) - CW'(1))
      else $error("reset released before full timeout");
   AST_WD_HELD: assert property (
      GATED && !gate_in |=> wd_cnt_q == '0 && !wd_on)
      else $error("watchdog timed with gate low");
   AST_FIRST_LONG: assert property (
      GATED && $rose(gate_in) |=> first_q && wd_limit == wd_long)
      else $error("first period after gate rise not long");
   AST_EARLY_FAULT: assert property (
      wd_on && kick_pulse && wd_cnt_q < early |=> wd_cnt_q == '0 &&
      (GATED || !reset_n_out))
      else $error("early kick not treated as fault");
   AST_EN_FOLLOW: assert property (
      $changed(en_follow_q) |->
      $past(en_cnt_q) == DW'(swr_pkg::REDL_CYC - 1))
      else $error("enable followed reset with wrong delay");
   AST_KICK_WIDTH: assert property (
      kick_pulse |-> watchdog_kick_in && $past(watchdog_kick_in, 8))
      else $error("kick accepted from a narrow pulse");
   AST_SWITCH_DELAY: assert property (
      $rose(sw_over_q) |-> $past(ovr_cnt_q) == SW'(SWITCH_DELAY - 1))
      else $error("switchover delay wrong");
   AST_KICK_RESTART: assert property (
      kick_ok && wd_run |=> wd_cnt_q == '0)
      else $error("valid kick did not restart period");
   AST_OD_ENABLE: assert property (
      enable_oe_n_out == enable_n_out && reset_oe_n_out == reset_n_out &&
      (GATED || reset_n_out == (rst_state_q == RST_IDLE)))
      else $error("open-drain output does not match reset state");
   COV_KICK_OK:   cover property (kick_ok);
   COV_EXPIRE:    cover property (wd_expire);
   COV_RELEASE:   cover property ($rose(reset_n_out));
   COV_SWITCHED:  cover property ($rose(sw_over_q));
endmodule

/* verilog/swr_pkg.sv */
// Constants, types and timing figures of the supervisory watchdog
package swr_pkg;

   // ----------------------------------------------------------------
   // Clock and time figures
   // ----------------------------------------------------------------
   localparam int  CLK_MHZ      = 200;
   localparam real TICK_US      = 1.0;
   localparam real KICK_MIN_US  = 6.5;
   localparam real KICK_IGN_US  = 1.0;
   localparam real REDL_US      = 1.5;
   localparam real RRDL_US      = 1.0;
   localparam real SWITCH_US    = 100.0;
   localparam real RST_MIN_MS   = 1.0;
   localparam real RST_TYP_MS   = 5.0;
   localparam real RST_MAX_MS   = 116.09;
   localparam real WP_MIN_MS    = 6.8;
   localparam real WP_MAX_MS    = 217.36;
   localparam int  LONG_X       = 8;

   // ----------------------------------------------------------------
   // Derived cycle counts
   // ----------------------------------------------------------------
   localparam int TICK_CYC     = int'($floor(TICK_US * CLK_MHZ));
   localparam int KICK_MIN_CYC = int'($ceil(KICK_MIN_US * CLK_MHZ));
   localparam int KICK_IGN_CYC = int'($ceil(KICK_IGN_US * CLK_MHZ));
   localparam int REDL_CYC     = int'($floor(REDL_US * CLK_MHZ));
   localparam int RRDL_CYC     = int'($floor(RRDL_US * CLK_MHZ));
   localparam int SWITCH_CYC   = int'($floor(SWITCH_US * CLK_MHZ));

   // ----------------------------------------------------------------
   // Period settings, in microsecond ticks
   // ----------------------------------------------------------------
   localparam int WP_W  = 18;
   localparam int RP_W  = 17;
   localparam int CNT_W = WP_W + 3;
   localparam logic [CNT_W-1:0] RST_MIN = CNT_W'(int'(RST_MIN_MS * 1000.0));
   localparam logic [CNT_W-1:0] RST_MAX = CNT_W'(int'(RST_MAX_MS * 1000.0));
   localparam logic [CNT_W-1:0] WP_MIN  = CNT_W'(int'(WP_MIN_MS * 1000.0));
   localparam logic [CNT_W-1:0] WP_MAX  = CNT_W'(int'(WP_MAX_MS * 1000.0));
   localparam logic [RP_W-1:0]  RST_TYP = RP_W'(int'(RST_TYP_MS * 1000.0));

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {WIN_100, WIN_50, WIN_75} swr_win_t;

   typedef struct packed {
      logic [WP_W-1:0] kick_period;
      logic [RP_W-1:0] reset_period;
      swr_win_t        window;
   } swr_cfg_t;

endpackage

/* testbench/swr_host_model.sv */
// Host processor model that sends watchdog kick pulses
`timescale 1ns/10ps

module swr_host_model (
   input  wire logic clk_in,
   output logic      kick_out
);

   // ----------------------------------------------------------------
   // Kick pulse driver
   // ----------------------------------------------------------------
   initial kick_out = 1'b0;

   // High for width rising edges; short widths only when a test asks
   task automatic kick(input int width);
      @(negedge clk_in);
      kick_out = 1'b1;
      repeat (width) @(negedge clk_in);
      kick_out = 1'b0;
   endtask

endmodule

/* testbench/swr_supervisor_tb.sv */
// Self-checking bench of the supervisory watchdog and reset block
`timescale 1ns/10ps

module swr_supervisor_tb;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   typedef struct {
      logic [1:0] win;
      int         width;
      logic       fault;
   } swr_row_t;

   logic              clk_in;
   logic              arst_n;
   logic              supply;
   logic              gate;
   logic              kick;
   swr_pkg::swr_cfg_t cfg;
   logic              rst_n;
   logic              rst_oe_n;
   logic              en_n;
   logic              en_oe_n;
   logic              g_rst_n;
   logic              g_rst_oe_n;
   logic              g_en_n;
   logic              g_en_oe_n;
   int                bad_count;
   int                total_checks;
   int                cycles;
   int                n;
   swr_row_t          rows [5];
   localparam int     TICK = 4;

   // Short tick keeps millisecond periods within the run budget
   swr_supervisor #(.TICK_CYCLES(TICK), .SWITCH_DELAY(50)) i_swr_supervisor (
      .clk_in           (clk_in),
      .arst_n_in        (arst_n),
      .cfg_in           (cfg),
      .supply_monitor_in(supply),
      .gate_in          (gate),
      .watchdog_kick_in (kick),
      .reset_n_out      (rst_n),
      .reset_oe_n_out   (rst_oe_n),
      .enable_n_out     (en_n),
      .enable_oe_n_out  (en_oe_n)
   );

   // Kick tied off: gated watchdog expiry is far beyond the run length
   swr_supervisor #(.GATED(1'b1), .TICK_CYCLES(TICK)) i_swr_supervisor_g (
      .clk_in           (clk_in),
      .arst_n_in        (arst_n),
      .cfg_in           (cfg),
      .supply_monitor_in(supply),
      .gate_in          (gate),
      .watchdog_kick_in (1'b0),
      .reset_n_out      (g_rst_n),
      .reset_oe_n_out   (g_rst_oe_n),
      .enable_n_out     (g_en_n),
      .enable_oe_n_out  (g_en_oe_n)
   );

   swr_host_model i_swr_host_model (
      .clk_in  (clk_in),
      .kick_out(kick)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wait_rel(output int cnt);
      cnt = 0;
      while (rst_n !== 1'b1 && cnt < 20000) begin
         @(negedge clk_in);
         cnt++;
      end
   endtask

   // Enable must lag reset release by the follow delay
   task automatic check_follow();
      repeat (290) @(negedge clk_in);
      check(en_n, 1'b0, "enable released early");
      repeat (20) @(negedge clk_in);
      check({en_oe_n, en_n}, 2'h3, "enable not released");
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 80000) begin
         bad_count++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      bad_count = 0;
      total_checks = 0;
      cycles = 0;
      arst_n = 1'b0;
      supply = 1'b1;
      gate = 1'b0;
      cfg.kick_period = 18'h01A90;
      cfg.reset_period = 17'h003E8;
      cfg.window = swr_pkg::WIN_100;
      rows = '{'{2'h0, 1300, 1'b0}, '{2'h1, 1299, 1'b0},
               '{2'h1, 1300, 1'b1}, '{2'h3, 1300, 1'b0},
               '{2'h2, 1300, 1'b1}};
      repeat (4) @(negedge clk_in);
      check({rst_oe_n, rst_n, en_n}, 3'h0, "outputs in reset");
      arst_n = 1'b1;
      repeat (5) @(negedge clk_in);
      check({g_rst_oe_n, g_rst_n, g_en_n, g_en_oe_n}, 4'hC,
            "gated idle");
      gate = 1'b1;
      wait_rel(n);
      check(n > 1000 * TICK - 10 && n <= 1000 * TICK, 1'b1,
            "power-on timeout wrong");
      check_follow();
      check(g_en_n, 1'b1, "gated enable held");
      foreach (rows[i]) begin
         cfg.window = swr_pkg::swr_win_t'(rows[i].win);
         i_swr_host_model.kick(rows[i].width);
         repeat (10) @(negedge clk_in);
         check({rst_oe_n, rst_n}, rows[i].fault ? 2'h0 : 2'h3,
               "kick outcome");
         if (rows[i].fault) begin
            wait_rel(n);
            check_follow();
         end
      end
      // Third fault: switchover beats the normal follow delay
      cfg.window = swr_pkg::WIN_50;
      i_swr_host_model.kick(1300);
      repeat (70) @(negedge clk_in);
      check({en_oe_n, en_n}, 2'h0, "switchover late");
      wait_rel(n);
      repeat (400) @(negedge clk_in);
      check(en_n, 1'b0, "switchover not sticky");
      // Supply dip with a separate reset timeout
      cfg.window = swr_pkg::WIN_100;
      cfg.reset_period = 17'h004B0;
      supply = 1'b0;
      repeat (2) @(negedge clk_in);
      check(rst_n, 1'b0, "supply fall slow");
      repeat (50) @(negedge clk_in);
      supply = 1'b1;
      wait_rel(n);
      check(n >= 1200 * TICK - 2 && n <= 1200 * TICK + 1, 1'b1,
            "reset timeout");
      // No kick at all: period expiry is a fault
      repeat (6800 * TICK - 10) @(negedge clk_in);
      check(rst_n, 1'b1, "watchdog expired early");
      repeat (20) @(negedge clk_in);
      check({rst_oe_n, rst_n}, 2'h0, "watchdog expiry missed");
      gate = 1'b0;
      repeat (320) @(negedge clk_in);
      check(g_en_n, 1'b0, "gated enable on gate fall");
      give_verdict();
   end

endmodule
